// ---- logic/asrr_serial_port.sv ----
// Serial readback port with register map of the converter
//
// Overview of operation
// - Read-result command shifts out held result
// - Result MSB on first rising edge after command
// - Field: optional status, data bytes, optional check
// - Commands ignored until read ends or deselect
// - Field replays from first byte when exhausted
// - Direct reads decode commands every byte boundary
// - Mid-read register or result read aborts output
// - New data starts first rising edge after command, or after count byte for a register read
// - Register write leaves ongoing output intact
// - Written byte that changes a restart-masked bit restarts conversion filter
// - Output buffer wraps cyclically to first byte
// - Deselect floats the combined output pin
// - Dedicated ready pin always driven
// - Select shows ready state on combined pin
// - Combined pin falls with dedicated ready pin
// - Eighteen byte registers, serial access only
// - Reset restores every register default
// - Block write applies each byte immediately
// - Register read: start address, then count
// - Register write: address, count, data MSB first
// - Ready pin returns high on third clk edge after first falling edge
`timescale 1ns/10ps
`default_nettype none

module asrr_serial_port
  import asrr_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          sclk,
  input  wire logic                          cs_n,
  input  wire logic                          din,
  input  wire asrr_result_t                  conv_in,
  input  wire logic                          conv_valid,
  input  wire logic [5:0]                    fault_flags,
  output logic                               result_ready_n,
  output logic                               serial_out_ready_combined,
  output logic                               serial_out_ready_combined_oe,
  output logic                               conv_restart,
  output logic [ASRR_NUM_REGS-1:0][7:0]      config_image
);

  asrr_frame_t f_r;
  asrr_frame_t f_nxt;
  asrr_regs_t  g_r;
  asrr_regs_t  g_nxt;
  asrr_out_t   o_r;
  asrr_out_t   o_nxt;
  asrr_core_t  c_r;
  asrr_core_t  c_nxt;
  logic [7:0]  sys_cfg;
  logic [7:0]  status_b;
  logic [7:0]  cur_tx;
  logic [7:0]  rx_byte;
  logic [7:0]  wr_new;
  logic        byte_done;
  logic [2:0]  last_idx;
  logic [2:0]  next_idx;

  function automatic logic [2:0] field_len(input logic [7:0] system_setup);
    return 3'(ASRR_DATA_BYTES) + {2'b00, system_setup[ASRR_SYS_STAT_BIT]}
           + {2'b00, system_setup[ASRR_SYS_CRC_BIT]};
  endfunction : field_len

  function automatic logic [7:0] field_byte(input asrr_result_t res,
                                            input logic [7:0]   stat,
                                            input logic [7:0]   system_setup,
                                            input logic [2:0]   idx);
    logic [2:0] k;
    k = (system_setup[ASRR_SYS_STAT_BIT] && idx != 3'd0) ? idx - 3'd1 : idx;
    if (system_setup[ASRR_SYS_STAT_BIT] && idx == 3'd0) begin
      return stat;
    end
    if (k < 3'(ASRR_DATA_BYTES)) begin
      return res.data[(ASRR_DATA_BYTES - 1 - int'(k)) * 8 +: 8];
    end
    return res.check;
  endfunction : field_byte

  function automatic logic [7:0] reg_byte(input logic [ASRR_NUM_REGS-1:0][7:0] file,
                                          input logic [5:0]                    flags,
                                          input logic [4:0]                    addr);
    if (addr >= 5'(ASRR_NUM_REGS)) begin
      return 8'h00;
    end
    if (addr == ASRR_OFS_IDENTITY) begin
      return ASRR_ID_VALUE;
    end
    if (addr == ASRR_OFS_FLAGS) begin
      return {file[ASRR_OFS_FLAGS][7], 1'b0, flags};
    end
    return file[addr];
  endfunction : reg_byte

  function automatic logic [ASRR_GRAY_W-1:0] gray_inc(input logic [ASRR_GRAY_W-1:0] g);
    logic [ASRR_GRAY_W-1:0] b;
    b = g;
    for (int i = ASRR_GRAY_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    b = b + 1'b1;
    return b ^ (b >> 1);
  endfunction : gray_inc

  function automatic logic [4:0] addr_step(input logic [4:0] a);
    return (a == 5'h1f) ? a : a + 5'h01;
  endfunction : addr_step

  // Link side: result word is only sampled while the clk side holds it still; flags pass a two-flop sync on sclk
  always_comb begin
    sys_cfg   = g_r.file[ASRR_OFS_SYSTEM];
    status_b  = reg_byte(g_r.file, g_r.flags_s2, ASRR_OFS_FLAGS);
    cur_tx    = f_r.started ? f_r.tx : field_byte(c_r.hold, status_b, sys_cfg, 3'd0);
    rx_byte   = {f_r.rx, din};
    byte_done = (f_r.bit_cnt == 3'd7);
    last_idx  = field_len(sys_cfg) - 3'd1;
    // A field shortened mid-frame must not leave the index stranded past its end
    next_idx  = (f_r.out_idx >= last_idx) ? 3'd0 : f_r.out_idx + 3'd1;
    wr_new    = 8'h00;
    f_nxt     = f_r;
    g_nxt     = g_r;
    f_nxt.started  = 1'b1;
    f_nxt.bit_cnt  = f_r.bit_cnt + 3'd1;
    f_nxt.rx       = rx_byte[6:0];
    f_nxt.tx       = {cur_tx[6:0], 1'b0};
    g_nxt.flags_s1 = fault_flags;
    g_nxt.flags_s2 = g_r.flags_s1;
    if (!f_r.started) begin
      g_nxt.rd_tog = ~g_r.rd_tog;
    end
    if (byte_done) begin
      // The stream keeps running beneath register writes and wraps around
      f_nxt.out_idx = next_idx;
      f_nxt.tx      = field_byte(c_r.hold, status_b, sys_cfg, next_idx);
      case (f_r.phase)
        ASRR_PH_STREAM: begin
          if (rx_byte[7:5] == ASRR_OP_REG_READ_CMD) begin
            f_nxt.phase = ASRR_PH_REG_READ_CMD_CNT;
            f_nxt.addr  = rx_byte[4:0];
          end else if (rx_byte[7:5] == ASRR_OP_REG_WRITE_CMD) begin
            f_nxt.phase = ASRR_PH_REG_WRITE_CMD_CNT;
            f_nxt.addr  = rx_byte[4:0];
          end else if (rx_byte == ASRR_OP_RDATA) begin
            f_nxt.phase   = ASRR_PH_RDATA_OUT;
            f_nxt.out_idx = 3'd0;
            f_nxt.tx      = field_byte(c_r.hold, status_b, sys_cfg, 3'd0);
          end
        end
        ASRR_PH_REG_READ_CMD_CNT: begin
          f_nxt.cnt   = rx_byte[4:0];
          f_nxt.phase = ASRR_PH_REG_READ_CMD_OUT;
          f_nxt.tx    = reg_byte(g_r.file, g_r.flags_s2, f_r.addr);
        end
        ASRR_PH_REG_READ_CMD_OUT: begin
          if (f_r.cnt == 5'd0) begin
            f_nxt.phase   = ASRR_PH_STREAM;
            f_nxt.out_idx = 3'd0;
            f_nxt.tx      = field_byte(c_r.hold, status_b, sys_cfg, 3'd0);
          end else begin
            f_nxt.addr = addr_step(f_r.addr);
            f_nxt.cnt  = f_r.cnt - 5'd1;
            f_nxt.tx   = reg_byte(g_r.file, g_r.flags_s2, addr_step(f_r.addr));
          end
        end
        ASRR_PH_REG_WRITE_CMD_CNT: begin
          f_nxt.cnt   = rx_byte[4:0];
          f_nxt.phase = ASRR_PH_REG_WRITE_CMD_DATA;
        end
        ASRR_PH_REG_WRITE_CMD_DATA: begin
          if (f_r.addr < 5'(ASRR_NUM_REGS)) begin
            wr_new = (g_r.file[f_r.addr] & ~ASRR_WRITE_MASK[f_r.addr])
                     | (rx_byte & ASRR_WRITE_MASK[f_r.addr]);
            if (((wr_new ^ g_r.file[f_r.addr]) & ASRR_RESTART_MASK[f_r.addr]) != 8'h00) begin
              g_nxt.restart_gray = gray_inc(g_r.restart_gray);
            end
            g_nxt.file[f_r.addr] = wr_new;
          end
          if (f_r.cnt == 5'd0) begin
            f_nxt.phase = ASRR_PH_STREAM;
          end else begin
            f_nxt.addr = addr_step(f_r.addr);
            f_nxt.cnt  = f_r.cnt - 5'd1;
          end
        end
        ASRR_PH_RDATA_OUT: begin
          if (f_r.out_idx == last_idx) begin
            f_nxt.phase = ASRR_PH_STREAM;
          end
        end
        default: begin
          f_nxt.phase = ASRR_PH_STREAM;
        end
      endcase
    end
    o_nxt.launched = 1'b1;
    o_nxt.bit_val  = cur_tx[7];
  end

  // Frame state ends with the frame itself, since the link clock stops when deselected
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end

  always_ff @(negedge sclk or posedge c_r.link_rst) begin
    if (c_r.link_rst) begin
      g_r <= '{file: ASRR_RESET_VALUES, default: '0};
    end else begin
      g_r <= g_nxt;
    end
  end

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      o_r <= '0;
    end else begin
      o_r <= o_nxt;
    end
  end

  // Clock side: results arriving during a readback wait in the stash
  always_comb begin
    c_nxt          = c_r;
    c_nxt.link_rst = 1'b0;
    c_nxt.restart  = 1'b0;
    c_nxt.busy_s1  = f_r.started;
    c_nxt.busy_s2  = c_r.busy_s1;
    c_nxt.tog_s1   = g_r.rd_tog;
    c_nxt.tog_s2   = c_r.tog_s1;
    c_nxt.gray_s1  = g_r.restart_gray;
    c_nxt.gray_s2  = c_r.gray_s1;
    if (c_r.gray_s2 != c_r.gray_seen) begin
      c_nxt.restart   = 1'b1;
      c_nxt.gray_seen = c_r.gray_s2;
    end
    if (c_r.tog_s2 != c_r.tog_seen) begin
      c_nxt.tog_seen = c_r.tog_s2;
      c_nxt.pending  = 1'b0;
    end
    if (conv_valid && c_r.busy_s2) begin
      c_nxt.stash   = conv_in;
      c_nxt.stash_v = 1'b1;
    end else if (conv_valid) begin
      c_nxt.hold    = conv_in;
      c_nxt.stash_v = 1'b0;
      c_nxt.pending = 1'b1;
    end else if (c_r.stash_v && !c_r.busy_s2) begin
      c_nxt.hold    = c_r.stash;
      c_nxt.stash_v = 1'b0;
      c_nxt.pending = 1'b1;
    end
    c_nxt.ready_n = ~c_nxt.pending;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      c_r <= '{link_rst: 1'b1, ready_n: 1'b1, default: '0};
    end else begin
      c_r <= c_nxt;
    end
  end

  // Before the first launch the combined pin mirrors the ready flop; after it the last bit stays
  assign serial_out_ready_combined    = o_r.launched ? o_r.bit_val : c_r.ready_n;
  assign serial_out_ready_combined_oe = ~cs_n;
  assign result_ready_n               = c_r.ready_n;
  assign conv_restart                 = c_r.restart;
  assign config_image                 = g_r.file;

  // Checks
  ready_fall_a: assert property (@(posedge clk) disable iff (rst)
    (conv_valid && !c_r.busy_s2) |=> !result_ready_n)
    else $error("ready pin did not fall after a new result");

  ready_release_a: assert property (@(posedge clk) disable iff (rst)
    (c_r.tog_s2 != c_r.tog_seen && !conv_valid && !c_r.stash_v) |=> result_ready_n)
    else $error("ready pin did not return high after readback start");

  restart_pulse_a: assert property (@(posedge clk) disable iff (rst)
    (c_r.gray_s2 != c_r.gray_seen) |=> (conv_restart && c_r.gray_seen == $past(c_r.gray_s2)))
    else $error("restart event not passed on");

  float_pin_a: assert property (@(posedge clk)
    cs_n |-> !serial_out_ready_combined_oe)
    else $error("combined pin driven while deselected");

  combined_ready_a: assert property (@(posedge clk) disable iff (rst)
    (!cs_n && !o_r.launched) |-> serial_out_ready_combined == result_ready_n)
    else $error("combined pin does not show ready state");

  reset_default_a: assert property (@(posedge clk)
    $fell(c_r.link_rst) |-> g_r.file == ASRR_RESET_VALUES)
    else $error("registers not at defaults after reset");

  rdata_first_a: assert property (@(negedge sclk) disable iff (cs_n)
    (byte_done && f_r.phase == ASRR_PH_STREAM && rx_byte == ASRR_OP_RDATA)
    |=> (f_r.phase == ASRR_PH_RDATA_OUT && f_r.out_idx == 3'd0
         && f_r.tx == field_byte(c_r.hold, status_b, sys_cfg, 3'd0)))
    else $error("result read does not start at the first byte");

  field_wrap_a: assert property (@(negedge sclk) disable iff (cs_n)
    (byte_done && f_r.out_idx == last_idx) |=> f_r.out_idx == 3'd0)
    else $error("output field did not wrap to the first byte");

  rdata_block_a: assert property (@(negedge sclk) disable iff (cs_n)
    (byte_done && f_r.phase == ASRR_PH_RDATA_OUT && f_r.out_idx != last_idx)
    |=> f_r.phase == ASRR_PH_RDATA_OUT)
    else $error("command accepted during result read");

  reg_write_cmd_keeps_a: assert property (@(negedge sclk) disable iff (cs_n)
    (byte_done && f_r.phase == ASRR_PH_STREAM && rx_byte[7:5] == ASRR_OP_REG_WRITE_CMD)
    |=> (f_r.out_idx == $past(next_idx) && f_r.phase == ASRR_PH_REG_WRITE_CMD_CNT))
    else $error("register write disturbed the output stream");

  reg_read_cmd_decode_a: assert property (@(negedge sclk) disable iff (cs_n)
    (byte_done && f_r.phase == ASRR_PH_STREAM && rx_byte[7:5] == ASRR_OP_REG_READ_CMD)
    ##8 byte_done |=> f_r.tx == reg_byte(g_r.file, g_r.flags_s2, $past(f_r.addr)))
    else $error("register read data not presented after count byte");

  write_apply_a: assert property (@(negedge sclk) disable iff (c_r.link_rst)
    (!cs_n && byte_done && f_r.phase == ASRR_PH_REG_WRITE_CMD_DATA && f_r.addr == ASRR_OFS_RATE)
    |=> g_r.file[ASRR_OFS_RATE] == $past(rx_byte))
    else $error("written byte not applied at once");

  ready_hold_a: assert property (@(posedge clk) disable iff (rst)
    (!result_ready_n && c_r.tog_s2 == c_r.tog_seen) |=> !result_ready_n)
    else $error("ready pin released without a readback");

  reg_write_cmd_count_a: assert property (@(negedge sclk) disable iff (cs_n)
    (byte_done && f_r.phase == ASRR_PH_REG_WRITE_CMD_CNT) |=> f_r.phase == ASRR_PH_REG_WRITE_CMD_DATA)
    else $error("count byte of a register write decoded as a command");

endmodule : asrr_serial_port

`default_nettype wire

// ---- pkg/asrr_pkg.sv ----
// Shared constants and types of the converter serial readback port
package asrr_pkg;

  localparam int ASRR_NUM_REGS   = 18;
  localparam int ASRR_DATA_BYTES = 2;
  localparam int ASRR_GRAY_W     = 3;

  localparam logic [4:0] ASRR_OFS_IDENTITY   = 5'h00;
  localparam logic [4:0] ASRR_OFS_FLAGS      = 5'h01;
  localparam logic [4:0] ASRR_OFS_INPUT_SEL  = 5'h02;
  localparam logic [4:0] ASRR_OFS_AMP        = 5'h03;
  localparam logic [4:0] ASRR_OFS_RATE       = 5'h04;
  localparam logic [4:0] ASRR_OFS_REFERENCE  = 5'h05;
  localparam logic [4:0] ASRR_OFS_EXC_MAG    = 5'h06;
  localparam logic [4:0] ASRR_OFS_EXC_ROUTE  = 5'h07;
  localparam logic [4:0] ASRR_OFS_BIAS       = 5'h08;
  localparam logic [4:0] ASRR_OFS_SYSTEM     = 5'h09;
  localparam logic [4:0] ASRR_OFS_RSVD_A     = 5'h0a;
  localparam logic [4:0] ASRR_OFS_OFS_LOW    = 5'h0b;
  localparam logic [4:0] ASRR_OFS_OFS_HIGH   = 5'h0c;
  localparam logic [4:0] ASRR_OFS_RSVD_D     = 5'h0d;
  localparam logic [4:0] ASRR_OFS_GAIN_LOW   = 5'h0e;
  localparam logic [4:0] ASRR_OFS_GAIN_HIGH  = 5'h0f;
  localparam logic [4:0] ASRR_OFS_IO_VALUES  = 5'h10;
  localparam logic [4:0] ASRR_OFS_IO_CONFIG  = 5'h11;

  // Index 17 first, index 0 last
  localparam logic [ASRR_NUM_REGS-1:0][7:0] ASRR_RESET_VALUES = {
    8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10,
    8'h00, 8'hff, 8'h00, 8'h10, 8'h14, 8'h00, 8'h01, 8'h80, 8'h00};
  localparam logic [ASRR_NUM_REGS-1:0][7:0] ASRR_WRITE_MASK = {
    8'h0f, 8'hff, 8'hff, 8'hff, 8'h00, 8'hff, 8'hff, 8'h00, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h80, 8'h00};
  localparam logic [ASRR_NUM_REGS-1:0][7:0] ASRR_RESTART_MASK = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'he0,
    8'h00, 8'hff, 8'h0f, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00};

  // Arbitrary identity value
  localparam logic [7:0] ASRR_ID_VALUE = 8'h03;

  localparam logic [2:0] ASRR_OP_REG_READ_CMD  = 3'h1;
  localparam logic [2:0] ASRR_OP_REG_WRITE_CMD  = 3'h2;
  localparam logic [7:0] ASRR_OP_RDATA = 8'h12;

  localparam int ASRR_SYS_STAT_BIT = 0;
  localparam int ASRR_SYS_CRC_BIT  = 1;

  typedef struct packed {
    logic [8*ASRR_DATA_BYTES-1:0] data;
    logic [7:0]                   check;
  } asrr_result_t;

  typedef enum logic [2:0] {
    ASRR_PH_STREAM, ASRR_PH_REG_READ_CMD_CNT, ASRR_PH_REG_READ_CMD_OUT,
    ASRR_PH_REG_WRITE_CMD_CNT, ASRR_PH_REG_WRITE_CMD_DATA, ASRR_PH_RDATA_OUT
  } asrr_phase_t;

  typedef struct packed {
    logic        started;
    asrr_phase_t phase;
    logic [2:0]  bit_cnt;
    logic [6:0]  rx;
    logic [7:0]  tx;
    logic [2:0]  out_idx;
    logic [4:0]  addr;
    logic [4:0]  cnt;
  } asrr_frame_t;

  typedef struct packed {
    logic [ASRR_NUM_REGS-1:0][7:0] file;
    logic [ASRR_GRAY_W-1:0]        restart_gray;
    logic                          rd_tog;
    logic [5:0]                    flags_s1;
    logic [5:0]                    flags_s2;
  } asrr_regs_t;

  typedef struct packed {
    logic launched;
    logic bit_val;
  } asrr_out_t;

  typedef struct packed {
    logic                   link_rst;
    logic                   busy_s1;
    logic                   busy_s2;
    logic                   tog_s1;
    logic                   tog_s2;
    logic                   tog_seen;
    logic [ASRR_GRAY_W-1:0] gray_s1;
    logic [ASRR_GRAY_W-1:0] gray_s2;
    logic [ASRR_GRAY_W-1:0] gray_seen;
    asrr_result_t           hold;
    asrr_result_t           stash;
    logic                   stash_v;
    logic                   pending;
    logic                   ready_n;
    logic                   restart;
  } asrr_core_t;

endpackage : asrr_pkg

// ---- verif/asrr_host.sv ----
// Host controller model that drives the serial link of the converter port
`timescale 1ns/10ps
`default_nettype none

module asrr_host (
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic pin
);

  // Link clock stands still low outside frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b0;
  end

  task automatic sel();
    #5 cs_n = 1'b0;
    #5;
  endtask : sel

  task automatic des();
    #5 cs_n = 1'b1;
    #5;
  endtask : des

  // 6 ns link period; din moves well away from the falling sample edge
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      #1 din = tx[i];
      #2 sclk = 1'b1;
      #3 rx[i] = pin;
      sclk = 1'b0;
    end
    #1 din = 1'b0;
  endtask : xfer

endmodule : asrr_host

`default_nettype wire

// ---- verif/asrr_serial_port_tb.sv ----
// Self-checking bench of the converter serial readback port
`timescale 1ns/10ps
`default_nettype none

module asrr_serial_port_tb;
  import asrr_pkg::*;

  logic                          clk, rst, sclk, cs_n, din, conv_valid;
  logic                          result_ready_n, pin_out, pin_oe, conv_restart;
  asrr_result_t                  conv_in;
  logic [5:0]                    fault_flags;
  logic [ASRR_NUM_REGS-1:0][7:0] config_image;
  int                            err_total, num_checks, cycles, restarts;
  wire logic                     pin_level = pin_oe ? pin_out : 1'bz;

  asrr_serial_port i_asrr_serial_port (
    .clk                         (clk),
    .rst                         (rst),
    .sclk                        (sclk),
    .cs_n                        (cs_n),
    .din                         (din),
    .conv_in                     (conv_in),
    .conv_valid                  (conv_valid),
    .fault_flags                 (fault_flags),
    .result_ready_n              (result_ready_n),
    .serial_out_ready_combined   (pin_out),
    .serial_out_ready_combined_oe(pin_oe),
    .conv_restart                (conv_restart),
    .config_image                (config_image)
  );

  asrr_host i_asrr_host (
    .sclk(sclk),
    .cs_n(cs_n),
    .din (din),
    .pin (pin_level)
  );

  always #20 clk = ~clk;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // Whole run needs about 130 cycles
  always @(posedge clk) begin
    cycles++;
    if (conv_restart === 1'b1) begin
      restarts++;
    end
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic xb(input logic [7:0] tx, input logic [7:0] exp);
    logic [7:0] rx;
    i_asrr_host.xfer(tx, rx);
    check(rx, exp);
  endtask : xb

  task automatic sb(input logic [7:0] tx);
    logic [7:0] rx;
    i_asrr_host.xfer(tx, rx);
  endtask : sb

  // Leaves time for the readback busy flag to clear before loading
  task automatic new_result(input logic [23:0] r);
    repeat (4) @(negedge clk);
    conv_in = r;
    conv_valid = 1'b1;
    @(negedge clk);
    conv_valid = 1'b0;
    check(result_ready_n, 1'b0);
  endtask : new_result

  task automatic s_reset();
    for (int i = 1; i < ASRR_NUM_REGS; i++) begin
      check(config_image[i], ASRR_RESET_VALUES[i]);
    end
    check(result_ready_n, 1'b1);
    check(pin_oe, 1'b0);
    check(restarts, 0);
  endtask : s_reset

  // Reads past the last register must give zeros
  task automatic s_regread();
    logic [7:0] e;
    fault_flags = 6'h2a;
    i_asrr_host.sel();
    sb(8'h20);
    sb(8'h13);
    for (int i = 0; i < 20; i++) begin
      e = (i >= ASRR_NUM_REGS) ? 8'h00 : ASRR_RESET_VALUES[i];
      if (i == 0) e = ASRR_ID_VALUE;
      if (i == 1) e = 8'haa;
      xb(8'h00, e);
    end
    i_asrr_host.des();
  endtask : s_regread

  task automatic s_rdata();
    new_result({16'ha5c3, 8'h5e});
    i_asrr_host.sel();
    check(pin_oe, 1'b1);
    check(pin_level, 1'b0);
    sb(ASRR_OP_RDATA);
    xb(8'h21, 8'ha5);
    xb(8'h00, 8'hc3);
    xb(8'h00, 8'ha5);
    xb(8'h00, 8'hc3);
    i_asrr_host.des();
    check(pin_oe, 1'b0);
    repeat (5) @(negedge clk);
    check(result_ready_n, 1'b1);
  endtask : s_rdata

  task automatic s_reg_write_cmd_mid();
    int r0;
    r0 = restarts;
    new_result({16'h1234, 8'h00});
    i_asrr_host.sel();
    xb(8'h43, 8'h12);
    xb(8'h01, 8'h34);
    xb(8'h33, 8'h12);
    check(config_image[3], 8'h33);
    check(config_image[4], ASRR_RESET_VALUES[4]);
    xb(8'h7f, 8'h34);
    check(config_image[4], 8'h7f);
    i_asrr_host.des();
    repeat (6) @(negedge clk);
    check(restarts > r0, 1'b1);
  endtask : s_reg_write_cmd_mid

  task automatic s_reg_read_cmd_mid();
    i_asrr_host.sel();
    check(pin_level, 1'b1);
    i_asrr_host.des();
    new_result({16'h6789, 8'h00});
    i_asrr_host.sel();
    xb(8'h23, 8'h67);
    xb(8'h00, 8'h89);
    xb(8'h00, 8'h33);
    check(pin_level, 1'b1);
    i_asrr_host.des();
  endtask : s_reg_read_cmd_mid

  // Status and check bytes switched on alone and together
  task automatic s_field_len();
    logic [7:0] f[4];
    int n;
    for (int k = 1; k <= 3; k++) begin
      i_asrr_host.sel();
      sb(8'h49);
      sb(8'h00);
      sb(8'h10 | 8'(k));
      i_asrr_host.des();
      check(config_image[9], 8'h10 | 8'(k));
      new_result({16'hbeef, 8'h3c});
      n = 2 + k[0] + k[1];
      if (k[0]) begin
        f = '{8'haa, 8'hbe, 8'hef, 8'h3c};
      end else begin
        f = '{8'hbe, 8'hef, 8'h3c, 8'h3c};
      end
      i_asrr_host.sel();
      sb(ASRR_OP_RDATA);
      for (int j = 0; j <= n; j++) begin
        xb(8'h00, f[j % n]);
      end
      i_asrr_host.des();
    end
  endtask : s_field_len

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    conv_valid = 1'b0;
    conv_in = '0;
    fault_flags = '0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    s_reset();
    s_regread();
    s_rdata();
    s_reg_write_cmd_mid();
    s_reg_read_cmd_mid();
    s_field_len();
    end_of_test();
  end

endmodule : asrr_serial_port_tb

`default_nettype wire
